// ---- rtl/bit_sync.sv ----
// Purpose: two flip-flop synchroniser, one per bit
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        stage1[i]   <= async_in[i];
        sync_out[i] <= stage1[i];
      end
    end
  endgenerate

endmodule

// ---- rtl/card_host_port.sv ----
// Purpose: host side pin logic of a flash card: reset, strobes, status, ultra dma link
// Assumes: host pins asynchronous; udma_clk independent of sys_clk
// Notes:   pins sharing one socket contact are separate outputs here
`timescale 1ns/10ps
module card_host_port (
  input  wire logic                                   sys_clk,
  input  wire logic                                   reset,
  input  wire logic                                   udma_clk,
  input  wire card_host_port_pkg::host_pins_t         pins,
  input  wire logic                                   udma_stop,
  input  wire logic                                   io_mode,
  input  wire logic                                   soft_reset,
  input  wire card_host_port_pkg::core_req_t          core,
  input  wire card_host_port_pkg::tx_word_t           tx,
  output logic                                        tx_ready,
  output logic                                        card_reset,
  output logic                                        ready_out,
  output logic                                        wait_n,
  output logic                                        wp_out,
  output logic                                        cfg_we,
  output logic                                        data_we,
  output logic                                        dmack_seen,
  output logic                                        vs1_o,
  output logic                                        vs1_oe,
  output logic                                        vs2_oe,
  output logic                                        ddmardy_n,
  output logic                                        dstrobe,
  output logic [card_host_port_pkg::DATA_W-1:0]       dout
);

  // pin synchronisers
  card_host_port_pkg::host_pins_t pins_s;

  bit_sync #(.WIDTH(card_host_port_pkg::PIN_SYNC_W)) u_pin_sync (
    .clk      (sys_clk),
    .async_in (pins),
    .sync_out (pins_s)
  );

  // mode decode
  card_host_port_pkg::mode_t mode;
  logic                      is_ide;
  logic                      is_mem;
  logic                      udma_any;

  always_comb begin
    if (!pins_s.ata_sel_n) begin
      mode = card_host_port_pkg::MODE_IDE;
    end else if (io_mode) begin
      mode = card_host_port_pkg::MODE_IO;
    end else begin
      mode = card_host_port_pkg::MODE_MEM;
    end
  end

  assign is_ide   = (mode == card_host_port_pkg::MODE_IDE);
  assign is_mem   = (mode == card_host_port_pkg::MODE_MEM);
  assign udma_any = is_ide && (core.udma_write || core.udma_read);

  // reset request
  logic pin_active;
  logic armed;
  logic rst_req;

  assign pin_active = is_ide ? !pins_s.reset_pin : pins_s.reset_pin;
  assign rst_req    = soft_reset || (is_ide ? pin_active : (pin_active && armed));

  // arms only once the pin has been seen inactive
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      armed <= 1'b0;
    end else if (!is_ide && !pins_s.reset_pin) begin
      armed <= 1'b1;
    end
  end

  // reset sequencer
  card_host_port_pkg::reset_state_t state;
  card_host_port_pkg::reset_state_t next_state;
  logic [card_host_port_pkg::CNT_W-1:0] init_cnt;

  always_comb begin
    case (state)
      card_host_port_pkg::ST_HOLD: begin
        next_state = rst_req ? card_host_port_pkg::ST_HOLD : card_host_port_pkg::ST_INIT;
      end
      card_host_port_pkg::ST_INIT: begin
        if (rst_req) begin
          next_state = card_host_port_pkg::ST_HOLD;
        end else if (init_cnt == card_host_port_pkg::RESET_CYCLES - card_host_port_pkg::CNT_ONE) begin
          next_state = card_host_port_pkg::ST_RUN;
        end else begin
          next_state = card_host_port_pkg::ST_INIT;
        end
      end
      card_host_port_pkg::ST_RUN: begin
        next_state = rst_req ? card_host_port_pkg::ST_HOLD : card_host_port_pkg::ST_RUN;
      end
      default: begin
        next_state = card_host_port_pkg::ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= card_host_port_pkg::ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || state != card_host_port_pkg::ST_INIT) begin
      init_cnt <= card_host_port_pkg::CNT_ZERO;
    end else begin
      init_cnt <= init_cnt + card_host_port_pkg::CNT_ONE;
    end
  end

  // status outputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      card_reset <= 1'b1;
      ready_out  <= 1'b0;
    end else begin
      card_reset <= (next_state != card_host_port_pkg::ST_RUN);
      ready_out  <= (next_state == card_host_port_pkg::ST_RUN) && !core.busy;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wait_n <= 1'b1;
    end else begin
      wait_n <= !(core.wait_req && !udma_any);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wp_out <= 1'b1;
    end else begin
      case (mode)
        card_host_port_pkg::MODE_MEM: wp_out <= (next_state != card_host_port_pkg::ST_RUN);
        card_host_port_pkg::MODE_IO:  wp_out <= !core.port16;
        card_host_port_pkg::MODE_IDE: wp_out <= !core.word_xfer;
        default:                      wp_out <= 1'b1;
      endcase
    end
  end

  // voltage sense straps
  always_ff @(posedge sys_clk) begin
    vs1_o  <= 1'b0;
    vs1_oe <= 1'b1;
    vs2_oe <= 1'b0;
  end

  // write strobe, acts on trailing edge
  logic we_q;
  logic we_rise;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      we_q <= 1'b1;
    end else begin
      we_q <= pins_s.we_n;
    end
  end

  assign we_rise = pins_s.we_n && !we_q && (state == card_host_port_pkg::ST_RUN);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_we  <= 1'b0;
      data_we <= 1'b0;
    end else begin
      case (mode)
        card_host_port_pkg::MODE_MEM: begin
          cfg_we  <= we_rise && !pins_s.reg_n;
          data_we <= we_rise && pins_s.reg_n;
        end
        card_host_port_pkg::MODE_IO: begin
          cfg_we  <= we_rise;
          data_we <= 1'b0;
        end
        default: begin
          cfg_we  <= 1'b0;
          data_we <= 1'b0;
        end
      endcase
    end
  end

  // dma acknowledge qualification
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dmack_seen <= 1'b0;
    end else begin
      dmack_seen <= core.dma_active && is_ide && !pins_s.dmack_n;
    end
  end

  // word handover towards the link domain
  logic                                  req_tgl;
  logic                                  ack_s;
  logic                                  accept;
  logic                                  next_req_tgl;
  logic [card_host_port_pkg::DATA_W-1:0] hold_data;

  assign accept       = tx.valid && tx_ready;
  assign next_req_tgl = req_tgl ^ accept;

  always_ff @(posedge sys_clk) begin
    if (reset || card_reset) begin // realign with link domain reset
      req_tgl   <= 1'b0;
      hold_data <= card_host_port_pkg::DATA_RESET;
    end else if (accept) begin
      req_tgl   <= !req_tgl;
      hold_data <= tx.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= (next_req_tgl == ack_s) && is_ide && core.udma_read && !card_reset;
    end
  end

  // link domain
  logic [card_host_port_pkg::LINK_SYNC_W-1:0] to_link;
  logic [card_host_port_pkg::LINK_SYNC_W-1:0] to_link_s;
  logic link_rst;
  logic req_l;
  logic wr_l;
  logic rd_l;
  logic rdy_l;
  logic stop_l;
  logic ack_tgl;
  logic new_word;

  assign to_link = {card_reset, req_tgl, is_ide && core.udma_write,
                    is_ide && core.udma_read, core.udma_ready, udma_stop};
  assign {link_rst, req_l, wr_l, rd_l, rdy_l, stop_l} = to_link_s;

  bit_sync #(.WIDTH(card_host_port_pkg::LINK_SYNC_W)) u_link_sync (
    .clk      (udma_clk),
    .async_in (to_link),
    .sync_out (to_link_s)
  );

  bit_sync #(.WIDTH(1)) u_ack_sync (
    .clk      (sys_clk),
    .async_in (ack_tgl),
    .sync_out (ack_s)
  );

  assign new_word = (req_l != ack_tgl) && rd_l && !stop_l;

  always_ff @(posedge udma_clk) begin
    if (link_rst) begin
      ack_tgl <= 1'b0;
      dstrobe <= 1'b0;
      dout    <= card_host_port_pkg::DATA_RESET;
    end else if (new_word) begin
      ack_tgl <= !ack_tgl;
      dstrobe <= !dstrobe;
      dout    <= hold_data;
    end
  end

  always_ff @(posedge udma_clk) begin
    if (link_rst) begin
      ddmardy_n <= 1'b1;
    end else begin
      ddmardy_n <= !(wr_l && rdy_l);
    end
  end

  // checks
  property p_dmack_ignored;
    @(posedge sys_clk) disable iff (reset)
      !core.dma_active |=> !dmack_seen;
  endproperty
  a_dmack_ignored: assert property (p_dmack_ignored) else $error("dmack seen without dma");

  property p_pin_reset;
    @(posedge sys_clk) disable iff (reset)
      (!is_ide && pins_s.reset_pin && armed) |=> card_reset;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not applied");

  property p_init_done;
    @(posedge sys_clk) disable iff (reset)
      (state == card_host_port_pkg::ST_INIT && !rst_req &&
       init_cnt == card_host_port_pkg::RESET_CYCLES - card_host_port_pkg::CNT_ONE)
      |=> (state == card_host_port_pkg::ST_RUN) && !card_reset;
  endproperty
  a_init_done: assert property (p_init_done) else $error("initial reset did not end");

  property p_soft_reset;
    @(posedge sys_clk) disable iff (reset)
      soft_reset |=> card_reset && !ready_out;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset ignored");

  property p_ide_reset;
    @(posedge sys_clk) disable iff (reset)
      (is_ide && !pins_s.reset_pin) |=> card_reset;
  endproperty
  a_ide_reset: assert property (p_ide_reset) else $error("ide reset ignored");

  property p_sense;
    @(posedge sys_clk) disable iff (reset)
      ##1 (!vs1_o && vs1_oe && !vs2_oe);
  endproperty
  a_sense: assert property (p_sense) else $error("sense straps wrong");

  property p_wait;
    @(posedge sys_clk) disable iff (reset)
      (!is_ide && core.wait_req) |=> !wait_n;
  endproperty
  a_wait: assert property (p_wait) else $error("wait not driven low");

  property p_we_mode;
    @(posedge sys_clk) disable iff (reset)
      (cfg_we || data_we) |-> !$past(is_ide);
  endproperty
  a_we_mode: assert property (p_we_mode) else $error("write strobe used in ide");

  property p_data_we_mem;
    @(posedge sys_clk) disable iff (reset)
      data_we |-> $past(is_mem);
  endproperty
  a_data_we_mem: assert property (p_data_we_mem) else $error("data write outside memory");

  property p_ready_busy;
    @(posedge sys_clk) disable iff (reset)
      card_reset |-> !ready_out;
  endproperty
  a_ready_busy: assert property (p_ready_busy) else $error("ready during reset");

  property p_wp_mem;
    @(posedge sys_clk) disable iff (reset)
      ($past(is_mem) && !card_reset) |-> !wp_out;
  endproperty
  a_wp_mem: assert property (p_wp_mem) else $error("write protect high after init");

  property p_ddmardy;
    @(posedge udma_clk) disable iff (link_rst)
      (wr_l && rdy_l) |=> !ddmardy_n;
  endproperty
  a_ddmardy: assert property (p_ddmardy) else $error("ddmardy not asserted");

  property p_strobe_pause;
    @(posedge udma_clk) disable iff (link_rst)
      (!new_word) |=> $stable(dstrobe) && $stable(dout);
  endproperty
  a_strobe_pause: assert property (p_strobe_pause) else $error("strobe edge without word");

endmodule

// ---- shared/card_host_port_pkg.sv ----
// Purpose: shared types and constants for the card host port block
// Assumes: sys_clk at 125 MHz; link clock independent
// Notes:   mode, reset sequencing and pin bundles
package card_host_port_pkg;

  // clock and reset timing
  localparam int SYS_PERIOD_NS = 8;
  localparam int RESET_TIME_NS = 1000;
  localparam int RESET_CYC_INT = (RESET_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int CNT_W         = 8;
  localparam logic [CNT_W-1:0] RESET_CYCLES = CNT_W'(RESET_CYC_INT);
  localparam logic [CNT_W-1:0] CNT_ZERO     = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE      = 8'h01;

  // data widths
  localparam int DATA_W = 16;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

  // synchroniser groups
  localparam int PIN_SYNC_W  = 5;
  localparam int LINK_SYNC_W = 6;

  typedef enum logic [1:0] {
    MODE_MEM = 2'b00,
    MODE_IO  = 2'b01,
    MODE_IDE = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_INIT = 2'b01,
    ST_RUN  = 2'b10
  } reset_state_t;

  // raw host pins, asynchronous to sys_clk
  typedef struct packed {
    logic reset_pin;
    logic we_n;
    logic reg_n;
    logic dmack_n;
    logic ata_sel_n;
  } host_pins_t;

  // requests from the card core, on sys_clk
  typedef struct packed {
    logic busy;
    logic wait_req;
    logic port16;
    logic word_xfer;
    logic dma_active;
    logic udma_write;
    logic udma_read;
    logic udma_ready;
  } core_req_t;

  // word from the core towards the ultra dma read burst
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } tx_word_t;

endpackage

// ---- verif/card_host_port_tb_top.sv ----
// Purpose: self-checking bench for the card host port
// Assumes: inputs change at falling sys_clk; udma_clk free running
// Notes:   host_model drives the host pins
`timescale 1ns/10ps
module card_host_port_tb_top;
  logic                                  sys_clk = 1'b0;
  logic                                  reset = 1'b1;
  logic                                  udma_clk = 1'b0;
  logic                                  io_mode = 1'b0;
  logic                                  soft_reset = 1'b0;
  card_host_port_pkg::core_req_t         core = '0;
  card_host_port_pkg::tx_word_t          tx = '0;
  card_host_port_pkg::host_pins_t        pins;
  logic                                  udma_stop;
  logic                                  tx_ready;
  logic                                  card_reset;
  logic                                  ready_out;
  logic                                  wait_n;
  logic                                  wp_out;
  logic                                  cfg_we;
  logic                                  data_we;
  logic                                  dmack_seen;
  logic                                  vs1_o;
  logic                                  vs1_oe;
  logic                                  vs2_oe;
  logic                                  ddmardy_n;
  logic                                  dstrobe;
  logic [15:0]                           dout;
  int                                    mismatches = 0;
  int                                    samples_checked = 0;

  always #4 sys_clk = ~sys_clk;
  initial begin
    #3;
    forever #40 udma_clk = ~udma_clk;
  end

  card_host_port card_host_port_i (.sys_clk, .reset, .udma_clk, .pins, .udma_stop, .io_mode,
    .soft_reset, .core, .tx, .tx_ready, .card_reset, .ready_out, .wait_n, .wp_out, .cfg_we,
    .data_we, .dmack_seen, .vs1_o, .vs1_oe, .vs2_oe, .ddmardy_n, .dstrobe, .dout);

  host_model host_model_i (.sys_clk, .dstrobe, .dout, .pins, .udma_stop);

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      $display("MISMATCH wait bound expected %0d seen %0d", lim - 1, n);
      close_out();
    end
  endtask

  task automatic wait_ready(output int n);
    for (n = 0; n < 300 && ready_out !== 1'b1; n++) @(negedge sys_clk);
    give_up(n, 300);
  endtask

  // pin high since power: one initial reset, then run
  task automatic t_power;
    int n;
    chk("card_reset", 1, card_reset);
    chk("ready_out", 0, ready_out);
    wait_ready(n);
    chk("init cycles", 16'(card_host_port_pkg::RESET_CYC_INT - 1), 16'(n));
    chk("card_reset", 0, card_reset);
    chk("wp_out", 0, wp_out);
    chk("sense", 16'h2, {vs1_o, vs1_oe, vs2_oe});
    $display("done power");
  endtask

  task automatic t_write(input logic reg_lvl, input int ec, input int ed);
    logic [15:0] c;
    logic [15:0] d;
    c = 16'h0000;
    d = 16'h0000;
    fork
      host_model_i.write_strobe(reg_lvl);
      repeat (14) begin
        @(posedge sys_clk);
        #1;
        c += cfg_we;
        d += data_we;
      end
    join
    chk("cfg_we pulses", 16'(ec), 16'(c));
    chk("data_we pulses", 16'(ed), 16'(d));
    $display("done write");
  endtask

  task automatic t_status;
    @(negedge sys_clk);
    core.wait_req = 1'b1;
    core.busy = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("wait_n", 0, wait_n);
    chk("ready_out busy", 0, ready_out);
    core.wait_req = 1'b0;
    core.busy = 1'b0;
    core.port16 = 1'b1;
    core.word_xfer = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("wait_n", 1, wait_n);
    chk("ready_out idle", 1, ready_out);
    chk("wp_out", io_mode | ~pins.ata_sel_n ? 0 : 0, wp_out);
    core.port16 = 1'b0;
    core.word_xfer = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("wp_out", io_mode | ~pins.ata_sel_n ? 1 : 0, wp_out);
    $display("done status");
  endtask

  task automatic t_dmack;
    host_model_i.set_pin(1, 1'b0);
    repeat (5) @(negedge sys_clk);
    chk("dmack idle", 0, dmack_seen);
    host_model_i.set_pin(1, 1'bx);
    repeat (5) @(negedge sys_clk);
    chk("dmack float", 0, dmack_seen);
    host_model_i.set_pin(1, 1'b0);
    core.dma_active = 1'b1;
    repeat (5) @(negedge sys_clk);
    chk("dmack dma", 1, dmack_seen);
    core.dma_active = 1'b0;
    host_model_i.set_pin(1, 1'b1);
    $display("done dmack");
  endtask

  // kinds: 0 memory pin, 1 io pin, 2 soft bit, 3 ide pin low
  task automatic t_reset(input int kind);
    int n;
    @(negedge sys_clk);
    io_mode = (kind == 1);
    if (kind == 2) soft_reset = 1'b1;
    if (kind < 2) host_model_i.set_pin(4, 1'b1);
    if (kind == 3) host_model_i.set_pin(0, 1'b0);
    repeat (6) @(negedge sys_clk);
    chk("card_reset", 1, card_reset);
    chk("ready_out", 0, ready_out);
    soft_reset = 1'b0;
    host_model_i.set_pin(4, kind == 3);
    wait_ready(n);
    chk("card_reset", 0, card_reset);
    $display("done reset %0d", kind);
  endtask

  task automatic send_word(input logic [15:0] w);
    int n;
    @(negedge sys_clk);
    tx = '{valid: 1'b1, data: w};
    for (n = 0; n < 200 && tx_ready !== 1'b1; n++) @(negedge sys_clk);
    give_up(n, 200);
    @(negedge sys_clk);
    tx.valid = 1'b0;
  endtask

  task automatic t_udma;
    int n;
    logic [15:0] w[4] = '{16'h1234, 16'hbeef, 16'h0f0f, 16'h8001};
    core.udma_write = 1'b1;
    core.udma_ready = 1'b1;
    for (n = 0; n < 80 && ddmardy_n !== 1'b0; n++) @(negedge sys_clk);
    give_up(n, 80);
    core.udma_ready = 1'b0;
    for (n = 0; n < 80 && ddmardy_n !== 1'b1; n++) @(negedge sys_clk);
    give_up(n, 80);
    core.udma_write = 1'b0;
    core.udma_read = 1'b1;
    host_model_i.rx_q.delete();
    for (int i = 0; i < 3; i++) send_word(w[i]);
    for (n = 0; n < 200 && host_model_i.rx_q.size() < 3; n++) @(negedge sys_clk);
    give_up(n, 200);
    host_model_i.udma_stop = 1'b1;
    send_word(w[3]);
    repeat (200) @(negedge sys_clk);
    chk("words paused", 3, 16'(host_model_i.rx_q.size()));
    host_model_i.udma_stop = 1'b0;
    for (n = 0; n < 200 && host_model_i.rx_q.size() < 4; n++) @(negedge sys_clk);
    give_up(n, 200);
    for (int i = 0; i < 4; i++) chk("read word", w[i], host_model_i.rx_q[i]);
    $display("done udma");
  endtask

  initial begin
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    t_power();
    t_write(1'b0, 1, 0);
    t_write(1'b1, 0, 1);
    t_status();
    io_mode = 1'b1;
    t_write(1'b1, 1, 0);
    t_status();
    io_mode = 1'b0;
    host_model_i.set_pin(0, 1'b0);
    t_write(1'b0, 0, 0);
    t_status();
    t_dmack();
    host_model_i.set_pin(0, 1'b1);
    host_model_i.set_pin(4, 1'b0);
    for (int k = 0; k < 4; k++) t_reset(k);
    t_udma();
    close_out();
  end
endmodule

// ---- verif/host_model.sv ----
// Purpose: host controller model driving the card pins
// Assumes: pin changes land at falling sys_clk
// Notes:   gathers ultra dma read words on both dstrobe edges
`timescale 1ns/10ps
module host_model (
  input  wire logic                                   sys_clk,
  input  wire logic                                   dstrobe,
  input  wire logic [card_host_port_pkg::DATA_W-1:0]  dout,
  output card_host_port_pkg::host_pins_t              pins,
  output logic                                        udma_stop
);
  logic [card_host_port_pkg::DATA_W-1:0] rx_q[$];

  // idle: strobes high, dma acknowledge high when unused
  initial begin
    pins = 5'h1f;
    udma_stop = 1'b0;
  end

  // each dstrobe edge carries one word
  always @(dstrobe) begin
    #1;
    rx_q.push_back(dout);
  end

  // pin index: 4 reset, 3 write, 2 attribute, 1 dma ack, 0 ide strap
  task automatic set_pin(input int idx, input logic lvl);
    @(negedge sys_clk);
    pins[idx] = lvl;
  endtask

  // write strobe, low then high, data taken on the rise
  task automatic write_strobe(input logic reg_lvl);
    @(negedge sys_clk);
    pins.reg_n = reg_lvl;
    pins.we_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    pins.we_n = 1'b1;
  endtask
endmodule
